// ### rpd_pkg.sv
// constants and types of the power-down control block
package rpd_pkg;
	localparam int         CLK_PERIOD_NS   = 100;
	localparam int         ADDR_W          = 3;
	localparam int         DATA_W          = 8;
	localparam int         TMR_W           = 20;

	localparam logic [2:0] ADDR_ICTRL      = 3'h0;
	localparam logic [2:0] ADDR_STATUS     = 3'h1;
	localparam logic [2:0] ADDR_MASK       = 3'h2;
	localparam logic [2:0] ADDR_STATE      = 3'h3;
	localparam logic [2:0] ADDR_CFG        = 3'h4;

	localparam int         ICTRL_ALARM_EN  = 4;
	localparam int         ICTRL_PSENSE_EN = 5;
	localparam int         ICTRL_PDOWN     = 6;
	localparam logic [7:0] ICTRL_WMASK     = 8'h70;
	localparam logic [7:0] ICTRL_RST       = 8'h00;

	localparam int         STAT_ALARM      = 0;
	localparam int         STAT_PSENSE     = 1;
	localparam logic [7:0] STATUS_WMASK    = 8'h03;
	localparam logic [7:0] STATUS_RST      = 8'h00;
	localparam logic [7:0] MASK_RST        = 8'h00;

	localparam int         STATE_PDOWN     = 0;
	localparam int         STATE_WAKE      = 1;
	localparam int         STATE_SUPPLY    = 2;
	localparam int         STATE_LINE_LOST = 3;
	localparam int         STATE_ALARM_PND = 4;

	localparam int         CFG_DELAY_ALARM = 0;
	localparam logic [7:0] CFG_WMASK       = 8'h01;
	localparam logic [7:0] CFG_RST         = 8'h00;

	localparam int         LINE_LOSS_US    = 25000;
	localparam int         LINE_LOSS_CYC   = LINE_LOSS_US * 1000 / CLK_PERIOD_NS;
	localparam int         ALARM_DELAY_US  = 8300;
	localparam int         ALARM_DELAY_CYC = ALARM_DELAY_US * 1000 / CLK_PERIOD_NS;

	localparam logic [2:0] CLKOUT_HALF     = 3'h5;
	localparam logic [4:0] WAKE_CYC        = 5'h10;

	typedef enum logic [2:0] {
		RPD_RUN  = 3'b001,
		RPD_DOWN = 3'b010,
		RPD_WAKE = 3'b100
	} rpd_state_e;
endpackage

// ### rpd_tmr_if.sv
// start, stop and expiry of a one-shot interval timer
`timescale 1ns/10ps
interface rpd_tmr_if;
	logic start;
	logic stop;
	logic expired;

	modport owner (output start, output stop, input expired);
	modport timer (input start, input stop, output expired);
endinterface

// ### rpd_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/10ps
module rpd_sync #(
	parameter int N = 2
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [N-1:0] async_in,
	output logic      [N-1:0] level
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] lvl;
	} rpd_sync_s;

	rpd_sync_s    q;
	rpd_sync_s    d;
	logic [N-1:0] lvl_next;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			assign lvl_next[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.lvl[i];
		end
	endgenerate

	always_comb begin
		d     = q;
		d.s1  = async_in;
		d.s2  = q.s1;
		d.s3  = q.s2;
		d.lvl = lvl_next;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level = q.lvl;
endmodule

// ### rpd_timer.sv
// one-shot interval timer, restartable
`timescale 1ns/10ps
module rpd_timer #(
	parameter int COUNT = 16
) (
	input  wire logic clk,
	input  wire logic arst_n,
	rpd_tmr_if.timer  tmr
);
	import rpd_pkg::*;

	typedef struct packed {
		logic [TMR_W-1:0] cnt;
		logic             run;
		logic             expired;
	} rpd_tmr_s;

	rpd_tmr_s q;
	rpd_tmr_s d;

	always_comb begin
		d         = q;
		d.expired = 1'b0;
		if (tmr.stop) begin
			d.run = 1'b0;
		end else if (tmr.start) begin
			d.cnt = TMR_W'(COUNT - 1);
			d.run = 1'b1;
		end else if (q.run) begin
			if (q.cnt == '0) begin
				d.expired = 1'b1;
				d.run     = 1'b0;
			end else begin
				d.cnt = q.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tmr.expired = q.expired;
endmodule

// ### rpd_ctrl.sv
// power-sense and power-down control with register port
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps

// Summary of operation
// - writing one to interrupt control bit 5 arms power sensing
// - lost line-frequency edges raise the power-sense interrupt
// - power-down holds host reset and clock output low, isolates serial port
// - supply sense rising above battery ends power-down and restores access
// - on restore, clock output resumes, supply enable and host reset go high
// - delayed-alarm units hold alarm interrupts back a fixed interval
// - a status read before the delayed alarm fires cancels it
module rpd_ctrl #(
	parameter int LINE_LOSS_CYCLES   = rpd_pkg::LINE_LOSS_CYC,
	parameter int ALARM_DELAY_CYCLES = rpd_pkg::ALARM_DELAY_CYC
) (
	input  wire logic                       clk,
	input  wire logic                       arst_n,
	input  wire logic [rpd_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [rpd_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [rpd_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                       line_freq_in,
	input  wire logic                       system_supply_sense,
	input  wire logic                       alarm_event,
	output logic                            irq,
	output logic                            host_reset_output_n,
	output logic                            supply_enable_output,
	output logic                            clk_out,
	output logic                            serial_isolate,
	output logic                            power_down
);
	import rpd_pkg::*;

	typedef struct packed {
		rpd_state_e        state;
		logic [DATA_W-1:0] ictrl;
		logic [DATA_W-1:0] status;
		logic [DATA_W-1:0] mask;
		logic [DATA_W-1:0] cfg;
		logic [DATA_W-1:0] rdata;
		logic              irq;
		logic              rst_n;
		logic              supply_en;
		logic              clk_out;
		logic              iso;
		logic              pdown;
		logic [2:0]        div;
		logic [4:0]        wake_cnt;
		logic              line_prev;
		logic              supply_prev;
		logic              psense_prev;
		logic              line_lost;
		logic              alarm_pend;
	} rpd_core_s;

	localparam rpd_core_s CORE_RST = '{
		state:       RPD_RUN,
		ictrl:       ICTRL_RST,
		status:      STATUS_RST,
		mask:        MASK_RST,
		cfg:         CFG_RST,
		rdata:       8'h00,
		irq:         1'b0,
		rst_n:       1'b1,
		supply_en:   1'b1,
		clk_out:     1'b0,
		iso:         1'b0,
		pdown:       1'b0,
		div:         3'h0,
		wake_cnt:    5'h00,
		line_prev:   1'b0,
		supply_prev: 1'b0,
		psense_prev: 1'b0,
		line_lost:   1'b0,
		alarm_pend:  1'b0
	};

	rpd_core_s q;
	rpd_core_s d;
	logic [1:0] pin_lvl;
	logic       line_lvl;
	logic       supply_lvl;
	logic       access_ok;
	logic       line_edge;
	logic       supply_rise;
	logic       psense_en;
	logic       line_start;
	logic       alarm_start;
	logic       alarm_stop;

	rpd_tmr_if line_tmr ();
	rpd_tmr_if alarm_tmr ();

	rpd_sync #(
		.N (2)
	) u_sync (
		.clk      (clk),
		.arst_n   (arst_n),
		.async_in ({system_supply_sense, line_freq_in}),
		.level    (pin_lvl)
	);

	rpd_timer #(
		.COUNT (LINE_LOSS_CYCLES)
	) u_line_tmr (
		.clk    (clk),
		.arst_n (arst_n),
		.tmr    (line_tmr.timer)
	);

	rpd_timer #(
		.COUNT (ALARM_DELAY_CYCLES)
	) u_alarm_tmr (
		.clk    (clk),
		.arst_n (arst_n),
		.tmr    (alarm_tmr.timer)
	);

	assign line_lvl    = pin_lvl[0];
	assign supply_lvl  = pin_lvl[1];
	assign access_ok   = (q.state == RPD_RUN);
	assign line_edge   = line_lvl ^ q.line_prev;
	assign supply_rise = supply_lvl & ~q.supply_prev;
	assign psense_en   = q.ictrl[ICTRL_PSENSE_EN];

	// line watchdog restarts on every line edge and on arming while in RPD_RUN; stop wins in other states
	assign line_start = psense_en & (line_edge | ~q.psense_prev);
	assign line_tmr.start = line_start;
	assign line_tmr.stop  = ~psense_en | (q.state != RPD_RUN);

	// delayed alarm path
	assign alarm_start = access_ok & alarm_event
		& q.ictrl[ICTRL_ALARM_EN] & q.cfg[CFG_DELAY_ALARM];
	assign alarm_stop  = access_ok & reg_rd
		& (reg_addr == ADDR_STATUS);
	assign alarm_tmr.start = alarm_start;
	assign alarm_tmr.stop  = alarm_stop & ~alarm_start;

	always_comb begin
		d             = q;
		d.rdata       = '0;
		d.line_prev   = line_lvl;
		d.supply_prev = supply_lvl;
		d.psense_prev = psense_en;

		// register writes, only while the port is connected
		if (access_ok && reg_wr) begin
			case (reg_addr)
				ADDR_ICTRL: begin
					d.ictrl = reg_wdata & ICTRL_WMASK;
				end
				ADDR_STATUS: begin
					d.status = q.status & ~(reg_wdata & STATUS_WMASK);
				end
				ADDR_MASK: begin
					d.mask = reg_wdata & STATUS_WMASK;
				end
				ADDR_CFG: begin
					d.cfg = reg_wdata & CFG_WMASK;
				end
				default: begin
					d.cfg = q.cfg;
				end
			endcase
		end

		// register reads, answered in the next cycle
		if (access_ok && reg_rd) begin
			case (reg_addr)
				ADDR_ICTRL: begin
					d.rdata = q.ictrl;
				end
				ADDR_STATUS: begin
					d.rdata = q.status;
				end
				ADDR_MASK: begin
					d.rdata = q.mask;
				end
				ADDR_STATE: begin
					d.rdata[STATE_PDOWN]     = (q.state == RPD_DOWN);
					d.rdata[STATE_WAKE]      = (q.state == RPD_WAKE);
					d.rdata[STATE_SUPPLY]    = supply_lvl;
					d.rdata[STATE_LINE_LOST] = q.line_lost;
					d.rdata[STATE_ALARM_PND] = q.alarm_pend;
				end
				ADDR_CFG: begin
					d.rdata = q.cfg;
				end
				default: begin
					d.rdata = '0;
				end
			endcase
		end

		// status read cancels a pending delayed alarm
		if (alarm_stop) begin
			d.alarm_pend = 1'b0;
		end

		// line loss detection
		if (line_edge) begin
			d.line_lost = 1'b0;
		end
		if (line_tmr.expired) begin
			d.line_lost = 1'b1;
			d.status[STAT_PSENSE] = 1'b1;
		end

		// alarm events, immediate or delayed
		if (access_ok && alarm_event && q.ictrl[ICTRL_ALARM_EN]) begin
			if (q.cfg[CFG_DELAY_ALARM]) begin
				d.alarm_pend = 1'b1;
			end else begin
				d.status[STAT_ALARM] = 1'b1;
			end
		end
		if (alarm_tmr.expired && q.alarm_pend) begin
			d.alarm_pend = 1'b0;
			d.status[STAT_ALARM] = 1'b1;
		end

		// clock output divider
		if (q.div == CLKOUT_HALF - 3'h1) begin
			d.div     = 3'h0;
			d.clk_out = ~q.clk_out;
		end else begin
			d.div = q.div + 3'h1;
		end

		// power-down sequence
		case (q.state)
			RPD_RUN: begin
				if (q.ictrl[ICTRL_PDOWN]) begin
					d.state     = RPD_DOWN;
					d.rst_n     = 1'b0;
					d.clk_out   = 1'b0;
					d.div       = 3'h0;
					d.supply_en = 1'b0;
					d.iso       = 1'b1;
					d.pdown     = 1'b1;
				end
			end
			RPD_DOWN: begin
				d.rst_n   = 1'b0;
				d.clk_out = 1'b0;
				d.div     = 3'h0;
				d.iso     = 1'b1;
				if (supply_rise) begin
					d.state     = RPD_WAKE;
					d.supply_en = 1'b1;
					d.pdown     = 1'b0;
					d.wake_cnt  = WAKE_CYC - 5'h01;
					d.ictrl[ICTRL_PDOWN] = 1'b0;
				end
			end
			RPD_WAKE: begin
				if (q.wake_cnt == 5'h00) begin
					d.state = RPD_RUN;
					d.rst_n = 1'b1;
					d.iso   = 1'b0;
				end else begin
					d.wake_cnt = q.wake_cnt - 5'h01;
				end
			end
			default: begin
				d.state     = RPD_RUN;
				d.rst_n     = 1'b1;
				d.supply_en = 1'b1;
				d.iso       = 1'b0;
				d.pdown     = 1'b0;
			end
		endcase

		d.irq = |(d.status & d.mask);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= CORE_RST;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata            = q.rdata;
	assign irq                  = q.irq;
	assign host_reset_output_n  = q.rst_n;
	assign supply_enable_output = q.supply_en;
	assign clk_out              = q.clk_out;
	assign serial_isolate       = q.iso;
	assign power_down           = q.pdown;
endmodule

// ### rpd_asserts.sv
// port checker of the power-down control block
`timescale 1ns/10ps
module rpd_asserts (
	input wire logic			clk,
	input wire logic			arst_n,
	input wire logic [rpd_pkg::ADDR_W-1:0]	reg_addr,
	input wire logic [rpd_pkg::DATA_W-1:0]	reg_wdata,
	input wire logic			reg_wr,
	input wire logic			reg_rd,
	input wire logic [rpd_pkg::DATA_W-1:0]	reg_rdata,
	input wire logic			line_freq_in,
	input wire logic			system_supply_sense,
	input wire logic			alarm_event,
	input wire logic			irq,
	input wire logic			host_reset_output_n,
	input wire logic			supply_enable_output,
	input wire logic			clk_out,
	input wire logic			serial_isolate,
	input wire logic			power_down
);
	import rpd_pkg::*;

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_pd_reset_low: assert property (
		power_down |-> !host_reset_output_n && !clk_out)
		else $error("reset or clock high in power-down");
	a_pd_isolated: assert property (
		power_down |-> serial_isolate)
		else $error("port not isolated in power-down");
	a_pd_enter: assert property (
		reg_wr && !serial_isolate && reg_addr == ADDR_ICTRL
		&& reg_wdata[ICTRL_PDOWN] |-> ##[1:2] power_down)
		else $error("power-down not entered");
	a_iso_rd_zero: assert property (
		serial_isolate && reg_rd |=> reg_rdata == 8'h00)
		else $error("read answered while isolated");
	a_wake_supply: assert property (
		$fell(power_down) |-> supply_enable_output)
		else $error("supply enable low at wake");
	a_wake_release: assert property (
		$fell(power_down) |-> ##[1:20]
		(host_reset_output_n && !serial_isolate))
		else $error("reset not released after wake");
	a_clk_runs: assert property (
		$changed(clk_out) && !power_down
		|-> ##5 ($changed(clk_out) || power_down))
		else $error("clock output stalled");
	a_rdata_slot: assert property (
		reg_rdata != 8'h00 |-> $past(reg_rd))
		else $error("read data outside its slot");
	a_irq_held: assert property (
		irq && !reg_wr && !$past(reg_wr) |=> irq)
		else $error("irq dropped without a write");
endmodule

bind rpd_ctrl rpd_asserts rpd_asserts_i (
	.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .line_freq_in(line_freq_in),
	.system_supply_sense(system_supply_sense),
	.alarm_event(alarm_event), .irq(irq),
	.host_reset_output_n(host_reset_output_n),
	.supply_enable_output(supply_enable_output),
	.clk_out(clk_out), .serial_isolate(serial_isolate),
	.power_down(power_down)
);

// ### rpd_env.sv
// line-frequency source and supply switch model
`timescale 1ns/10ps
module rpd_env (
	input  wire logic	clk,
	input  wire logic	line_on,
	input  wire logic	supply_on,
	output logic		line_freq_in,
	output logic		system_supply_sense
);
	logic [2:0] cnt_q  = 3'h0;
	logic       line_q = 1'b0;
	always @(posedge clk) begin
		cnt_q <= cnt_q + 3'h1;
		if (line_on && cnt_q == 3'h7)
			line_q <= !line_q;
	end
	assign line_freq_in = line_q;
	assign system_supply_sense = supply_on;
endmodule

// ### tb_top.sv
// testbench of the power-down control block
`timescale 1ns/10ps
module tb_top;
	import rpd_pkg::*;
	logic		clk = 1'b0;
	logic		arst_n = 1'b0;
	logic [2:0]	reg_addr = 3'h0;
	logic [7:0]	reg_wdata = 8'h00;
	logic		reg_wr = 1'b0;
	logic		reg_rd = 1'b0;
	logic		alarm_event = 1'b0;
	logic		line_on = 1'b1;
	logic		supply_on = 1'b1;
	logic [7:0]	reg_rdata;
	logic		line_freq_in, system_supply_sense, irq;
	logic		host_reset_output_n, supply_enable_output;
	logic		clk_out, serial_isolate, power_down;
	int		n_mismatch = 0;
	int		checked = 0;
	int		cyc = 0;
	always #(CLK_PERIOD_NS / 2) clk = !clk;
	rpd_env rpd_env_i (.clk(clk), .line_on(line_on),
		.supply_on(supply_on), .line_freq_in(line_freq_in),
		.system_supply_sense(system_supply_sense));
	rpd_ctrl #(.LINE_LOSS_CYCLES(40), .ALARM_DELAY_CYCLES(20)) rpd_ctrl_i (
		.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .line_freq_in(line_freq_in),
		.system_supply_sense(system_supply_sense),
		.alarm_event(alarm_event), .irq(irq),
		.host_reset_output_n(host_reset_output_n),
		.supply_enable_output(supply_enable_output),
		.clk_out(clk_out), .serial_isolate(serial_isolate),
		.power_down(power_down));
	task automatic conclude();
		if (n_mismatch == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, s);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rc(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk("reg_rdata", e, reg_rdata);
	endtask
	task automatic alarm();
		@(posedge clk);
		alarm_event <= 1'b1;
		@(posedge clk);
		alarm_event <= 1'b0;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		w(6);
		chk("host_reset_n", 8'h01, 8'(host_reset_output_n));
		chk("supply_enable", 8'h01, 8'(supply_enable_output));
		rc(ADDR_ICTRL, 8'h00);
		wr(ADDR_MASK, 8'h03);
		rc(ADDR_MASK, 8'h03);
		rc(3'h7, 8'h00);
		wr(ADDR_ICTRL, 8'h10);
		alarm();
		w(2);
		chk("irq", 8'h01, 8'(irq));
		rc(ADDR_STATUS, 8'h01);
		wr(ADDR_STATUS, 8'h01);
		w(2);
		chk("irq", 8'h00, 8'(irq));
		wr(ADDR_CFG, 8'h01);
		alarm();
		w(8);
		rc(ADDR_STATUS, 8'h00);
		w(30);
		chk("irq", 8'h00, 8'(irq));
		alarm();
		w(8);
		chk("irq", 8'h00, 8'(irq));
		rc(ADDR_STATE, 8'h14);
		w(25);
		chk("irq", 8'h01, 8'(irq));
		rc(ADDR_STATUS, 8'h01);
		wr(ADDR_STATUS, 8'h01);
		wr(ADDR_CFG, 8'h00);
		wr(ADDR_ICTRL, 8'h20);
		w(80);
		chk("irq", 8'h00, 8'(irq));
		@(posedge clk) line_on <= 1'b0;
		w(60);
		chk("irq", 8'h01, 8'(irq));
		rc(ADDR_STATUS, 8'h02);
		w(50);
		rc(ADDR_STATUS, 8'h02);
		rc(ADDR_STATE, 8'h0c);
		wr(ADDR_ICTRL, 8'h40);
		w(3);
		chk("host_reset_n", 8'h00, 8'(host_reset_output_n));
		chk("clk_out", 8'h00, 8'(clk_out));
		chk("serial_isolate", 8'h01, 8'(serial_isolate));
		chk("supply_enable", 8'h00, 8'(supply_enable_output));
		wr(ADDR_MASK, 8'h00);
		rc(ADDR_MASK, 8'h00);
		@(posedge clk) supply_on <= 1'b0;
		w(20);
		chk("power_down", 8'h01, 8'(power_down));
		@(posedge clk) supply_on <= 1'b1;
		w(30);
		chk("host_reset_n", 8'h01, 8'(host_reset_output_n));
		chk("supply_enable", 8'h01, 8'(supply_enable_output));
		chk("serial_isolate", 8'h00, 8'(serial_isolate));
		rc(ADDR_MASK, 8'h03);
		rc(ADDR_ICTRL, 8'h00);
		rc(ADDR_STATE, 8'h0c);
		wr(ADDR_STATUS, 8'h03);
		w(2);
		chk("irq", 8'h00, 8'(irq));
		conclude();
	end
endmodule
